// ==== hw/ext_area_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) eight areas, one low chip select each
// (RULE2) width bits: 01 is 16-bit, 11 8-bit
// (RULE3) width register resets to FEFF or FFFF
// (RULE4) software avoids 8-bit on byte-control areas
// (RULE5) access bit 0: two states, no waits
// (RULE6) access bit 1: three states, waits allowed
// (RULE7) access register low byte reads zero
// (RULE8) low wait input stretches the access
// (RULE9) program wait count set per area
// (RULE10) burst rom only areas 0 and 1
// (RULE11) multiplexed i/o only areas 3 to 7
// (RULE12) byte-control sram on any area
// (RULE13) idle cycles in four listed cases
// (RULE14) per-area extension keeps chip select low
// (RULE15) selectable read strobe negation timing
// (RULE16) buffered writes let masters continue early
// (RULE17) arbitrate cpu, dma, dtc, external master
// (RULE18) external cycles paced by bus clock edges
// (RULE19) per-area byte swap for little endian
// (RULE20) three-bit wait field gives 0 to 7
// (RULE21) width strap caught once during reset
module ext_area_ctrl
    import ext_area_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // internal masters: 0 cpu, 1 dma, 2 dtc
    input  wire logic [2:0]  req_i,
    input  wire logic [8:0]  req_area_i,
    input  wire logic [2:0]  req_write_i,
    input  wire logic [47:0] req_wdata_i,
    input  wire logic        dma_single_i,
    output logic      [2:0]  ack_o,
    output logic      [15:0] rdata_o,
    // external pins
    input  wire logic        bus_clk_i,
    input  wire logic        wait_n_i,
    input  wire logic        bus_req_n_i,
    input  wire logic        strap_16bit_i,
    output logic      [7:0]  area_chip_select_n_o,
    output logic             bus_start_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             read_write_o,
    output logic             addr_latch_o,
    output logic             upper_byte_n_o,
    output logic             lower_byte_n_o,
    output logic             bus_ack_n_o,
    input  wire logic [15:0] data_i,
    output logic      [15:0] data_o,
    output logic             data_oe_o
);

    typedef struct packed {
        logic [15:0] width;
        logic [7:0]  access;
        logic [23:0] waits;
        logic [7:0]  csext;
        logic [6:0]  ctrl;
        logic [7:0]  bctl;
        logic [7:0]  mux;
        logic [7:0]  burst;
        logic [3:0]  blen;
        logic [7:0]  endian;
        logic [31:0] prdata;
        logic [2:0]  lclk;
        logic [1:0]  wsync;
        logic [1:0]  rsync;
        logic [1:0]  strap;
        logic [31:0] dsync;
        bus_state_e  st;
        logic [2:0]  area;
        logic        we;
        logic [1:0]  mst;
        logic        acked;
        logic        sgl;
        logic [15:0] wd;
        logic [2:0]  wcnt;
        logic [1:0]  bcnt;
        logic [15:0] rdata;
        logic [2:0]  ack;
        logic        last_v;
        logic        last_rd;
        logic        last_sgl;
        logic [2:0]  last_area;
    } state_s;

    state_s s;
    state_s next_s;

    logic apb_hit;
    logic be;
    logic wait_act;
    logic is3;
    logic eight;

    // address decode used only by the error logic
    always_comb begin
        case (paddr_i)
            OFS_WIDTH, OFS_ACCESS, OFS_WAIT_U, OFS_WAIT_L, OFS_CSEXT,
            OFS_CTRL, OFS_MODE, OFS_ENDIAN, OFS_STATUS: apb_hit = 1'b1;
            default: apb_hit = 1'b0;
        endcase
    end

    assign be       = s.lclk[1] & ~s.lclk[2];           // [RULE18]
    assign wait_act = ~s.wsync[1];
    assign is3      = s.access[s.area];
    assign eight    = s.width[WIDTH_HIGH_POS + 32'(s.area)];  // [RULE2]

    // wait field as laid out in a register: 3 bits per nibble
    function automatic logic [15:0] wait_word(input logic [11:0] w);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            r[4*i +: 3] = w[3*i +: 3];
        end
        return r;
    endfunction

    function automatic logic [11:0] wait_unpack(input logic [15:0] v);
        logic [11:0] r;
        r = 12'h000;
        for (int i = 0; i < 4; i++) begin
            r[3*i +: 3] = v[4*i +: 3];
        end
        return r;
    endfunction

    // all next-state logic; synchronous reset applied last
    always_comb begin
        logic       take;
        logic       fin;
        logic       done;
        logic [1:0] m;
        logic [2:0] ar;
        logic       rd_in;
        logic [15:0] din;
        logic [15:0] wsel;
        take  = 1'b0;
        fin   = 1'b0;
        done  = 1'b0;
        m     = 2'd0;
        ar    = 3'd0;
        rd_in = 1'b0;
        din   = 16'h0000;
        wsel  = 16'h0000;
        next_s = s;
        next_s.ack   = 3'b000;
        // pins pass two flops before any use
        next_s.lclk  = {s.lclk[1:0], bus_clk_i};
        next_s.wsync = {s.wsync[0], wait_n_i};
        next_s.rsync = {s.rsync[0], ~bus_req_n_i};
        next_s.strap = {s.strap[0], strap_16bit_i};
        next_s.dsync = {s.dsync[15:0], data_i};

        // register reads captured in the setup cycle
        if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                OFS_WIDTH:  next_s.prdata = {16'h0000, s.width};
                OFS_ACCESS: next_s.prdata = {16'h0000, s.access, 8'h00}; // [RULE7]
                OFS_WAIT_U: next_s.prdata = {16'h0000, wait_word(s.waits[23:12])};
                OFS_WAIT_L: next_s.prdata = {16'h0000, wait_word(s.waits[11:0])};
                OFS_CSEXT:  next_s.prdata = {24'h000000, s.csext};
                OFS_CTRL:   next_s.prdata = {25'h0000000, s.ctrl};
                OFS_MODE:   next_s.prdata = {10'h000, s.blen, s.burst[1:0],
                                             s.mux, s.bctl};
                OFS_ENDIAN: next_s.prdata = {24'h000000, s.endian};
                OFS_STATUS: next_s.prdata = {26'h0000000, s.last_rd, s.area,
                                             s.st == ST_REL, s.st != ST_IDLE};
                default:    next_s.prdata = 32'h00000000;
            endcase
        end

        // register writes take effect in the access cycle
        if (psel_i && penable_i && pwrite_i) begin
            case (paddr_i)
                OFS_WIDTH:  next_s.width  = pwdata_i[15:0];       // [RULE2]
                OFS_ACCESS: next_s.access = pwdata_i[15:8];       // [RULE7]
                OFS_WAIT_U: next_s.waits[23:12] = wait_unpack(pwdata_i[15:0]);
                OFS_WAIT_L: next_s.waits[11:0]  = wait_unpack(pwdata_i[15:0]);
                OFS_CSEXT:  next_s.csext  = pwdata_i[7:0];
                OFS_CTRL:   next_s.ctrl   = pwdata_i[6:0];
                OFS_MODE: begin
                    next_s.bctl  = pwdata_i[MODE_BCTL_POS +: 8];  // [RULE12]
                    next_s.mux   = pwdata_i[MODE_MUX_POS +: 8] & MUX_AREAS; // [RULE11]
                    next_s.burst = pwdata_i[MODE_BURST_POS +: 8] & BURST_AREAS; // [RULE10]
                    next_s.blen  = pwdata_i[MODE_BLEN_POS +: 4];
                end
                OFS_ENDIAN: next_s.endian = pwdata_i[7:0];
                default: ;
            endcase
        end

        // external access engine, stepped on bus clock rising edges
        if (be) begin
            case (s.st)
                ST_IDLE: begin
                    if (s.rsync[1] && s.ctrl[CTRL_REL_EN]) begin
                        next_s.st = ST_REL;                       // [RULE17]
                    end else if (|req_i) begin
                        take = 1'b1;
                    end
                end
                ST_REL: if (!s.rsync[1]) next_s.st = ST_IDLE;
                ST_GAP: next_s.st = s.mux[s.area] ? ST_ADDR : ST_T1;
                ST_ADDR: next_s.st = ST_T1;
                ST_T1: next_s.st = ST_T2;
                ST_T2: begin
                    if (!is3) begin
                        fin = 1'b1;                               // [RULE5]
                    end else if (s.wcnt != 3'd0 || wait_act) begin
                        next_s.st = ST_WAIT;                      // [RULE6]
                    end else begin
                        next_s.st = ST_T3;
                    end
                end
                ST_WAIT: begin
                    if (s.wcnt != 3'd0) next_s.wcnt = s.wcnt - 3'd1; // [RULE20]
                    if (s.wcnt <= 3'd1 && !wait_act) begin
                        next_s.st = ST_T3;                        // [RULE8]
                    end
                end
                ST_T3: fin = 1'b1;
                ST_BURST: begin
                    rd_in = 1'b1;
                    next_s.bcnt = s.bcnt - 2'd1;
                    if (s.bcnt == 2'd1) done = 1'b1;
                end
                ST_EXT: next_s.st = ST_IDLE;
                default: next_s.st = ST_IDLE;
            endcase
        end

        // accept a request: fixed priority cpu, dma, dtc
        if (take) begin
            m  = req_i[0] ? 2'd0 : (req_i[1] ? 2'd1 : 2'd2);  // [RULE17]
            ar = req_area_i[3*m +: 3];
            wsel = req_wdata_i[16*m +: 16];
            next_s.mst  = m;
            next_s.area = ar;
            next_s.we   = req_write_i[m];
            next_s.sgl  = (m == 2'd1) && dma_single_i;
            next_s.wd   = (s.endian[ar] && !s.width[WIDTH_HIGH_POS + 32'(ar)])
                          ? {wsel[7:0], wsel[15:8]} : wsel;     // [RULE19]
            next_s.wcnt = s.access[ar] ? s.waits[WAIT_BITS*ar +: 3]
                                       : 3'd0;                 // [RULE9]
            next_s.acked = req_write_i[m] && s.ctrl[CTRL_WBUF_EN];
            if (req_write_i[m] && s.ctrl[CTRL_WBUF_EN]) begin
                next_s.ack[m] = 1'b1;                            // [RULE16]
            end
            // idle insertion cases
            if (s.last_v &&
                ((s.ctrl[0] && s.last_rd && !req_write_i[m] &&
                  s.last_area != ar) ||
                 (s.ctrl[1] && s.last_rd && req_write_i[m]) ||
                 (s.ctrl[2] && !s.last_rd && !req_write_i[m]) ||
                 (s.ctrl[3] && s.last_sgl))) begin
                next_s.st = ST_GAP;                              // [RULE13]
            end else begin
                next_s.st = s.mux[ar] ? ST_ADDR : ST_T1;         // [RULE11]
            end
            next_s.last_v    = 1'b1;
            next_s.last_rd   = !req_write_i[m];
            next_s.last_sgl  = (m == 2'd1) && dma_single_i;
            next_s.last_area = ar;
        end

        // end of the basic cycle, maybe followed by burst beats
        if (fin) begin
            rd_in = !s.we;
            if (!s.we && s.burst[s.area] && s.blen[2*s.area[0] +: 2] != 2'd0) begin
                next_s.bcnt = s.blen[2*s.area[0] +: 2];          // [RULE10]
                next_s.st   = ST_BURST;
            end else begin
                done = 1'b1;
            end
        end

        // read data: byte lane and endian handling
        if (rd_in) begin
            din = s.dsync[31:16];
            if (eight) begin
                next_s.rdata = {8'h00, din[7:0]};
            end else if (s.endian[s.area]) begin
                next_s.rdata = {din[7:0], din[15:8]};            // [RULE19]
            end else begin
                next_s.rdata = din;
            end
        end

        if (done) begin
            next_s.st = s.csext[s.area] ? ST_EXT : ST_IDLE;      // [RULE14]
            if (!s.acked) next_s.ack[s.mst] = 1'b1;
        end

        // synchronous reset; bus clock and strap syncs keep running, wait sync set to 11, other syncs cleared, strap caught here
        if (!resetn_i) begin
            next_s = '0;
            next_s.lclk   = {s.lclk[1:0], bus_clk_i};
            next_s.strap  = {s.strap[0], strap_16bit_i}; // [RULE21]
            next_s.wsync  = 2'b11;
            next_s.width  = s.strap[1] ? WIDTH_RST_16 : WIDTH_RST_8; // [RULE3]
            next_s.access = ACCESS_RST;                              // [RULE6]
            next_s.waits  = WAIT_RST;
            next_s.ctrl   = CTRL_RST;
        end
    end

    // single state register
    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    // apb answers in its first access cycle
    assign prdata_o  = s.prdata;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~apb_hit;
    assign ack_o     = s.ack;
    assign rdata_o   = s.rdata;

    // pin decode from the engine state
    logic act;
    logic strb;
    assign act  = s.st inside {ST_ADDR, ST_T1, ST_T2, ST_WAIT, ST_T3,
                               ST_BURST, ST_EXT};
    assign strb = s.st inside {ST_T1, ST_T2, ST_WAIT, ST_T3, ST_BURST};
    assign area_chip_select_n_o = act ? ~(8'h01 << s.area) : 8'hFF; // [RULE1]
    assign bus_start_n_o  = ~(s.st == ST_T1);
    // early negation trades read hold time for bus turnaround
    assign rd_n_o = ~(!s.we && strb &&
                      !(s.ctrl[CTRL_RD_EARLY] && s.st == ST_T3)); // [RULE15]
    assign wr_n_o = ~(s.we && s.st inside {ST_T2, ST_WAIT, ST_T3});
    assign read_write_o   = act ? !s.we : 1'b1;
    assign addr_latch_o   = s.st == ST_ADDR;
    // relies on software never pairing byte control with 8-bit width
    assign lower_byte_n_o = ~(act && s.bctl[s.area]);          // [RULE4]
    assign upper_byte_n_o = ~(act && s.bctl[s.area] && !eight); // [RULE12]
    assign bus_ack_n_o    = ~(s.st == ST_REL);
    assign data_o  = (s.st == ST_ADDR) ? {13'h0000, s.area} : s.wd;
    assign data_oe_o = (s.st == ST_ADDR) ||
                       (s.we && s.st inside {ST_T1, ST_T2, ST_WAIT, ST_T3});

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_one_select: assert property ($onehot0(~area_chip_select_n_o)) // [RULE1]
        else $error("more than one chip select low");
    a_select_area: assert property ( // [RULE1]
        s.st == ST_T1 |-> !area_chip_select_n_o[s.area])
        else $error("accessed area select not low");
    a_width_reset: assert property ( // [RULE3]
        $rose(resetn_i) |-> s.width == WIDTH_RST_16 || s.width == WIDTH_RST_8)
        else $error("bad width reset value");
    a_two_state: assert property (s.st == ST_WAIT |-> is3) // [RULE5]
        else $error("wait state in two-state area");
    a_low_zero: assert property ( // [RULE7]
        psel_i && !penable_i && !pwrite_i && paddr_i == OFS_ACCESS
        |=> prdata_o[7:0] == 8'h00)
        else $error("access register low byte not zero");
    a_wait_pin: assert property ( // [RULE8]
        s.st == ST_WAIT && be && s.wcnt <= 3'd1 && wait_act
        |=> s.st == ST_WAIT)
        else $error("wait input ignored");
    a_prog_wait: assert property ( // [RULE20]
        s.st == ST_WAIT && be && s.wcnt > 3'd1
        |=> s.st == ST_WAIT && s.wcnt == $past(s.wcnt) - 3'd1)
        else $error("program wait cut short");
    a_burst_area: assert property ( // [RULE10]
        s.st == ST_BURST |-> s.area <= 3'd1)
        else $error("burst outside areas 0 and 1");
    a_mux_area: assert property ( // [RULE11]
        s.st == ST_ADDR |-> s.area >= 3'd3)
        else $error("multiplexed cycle outside areas 3 to 7");
    a_ext_select: assert property ( // [RULE14]
        s.st == ST_EXT |-> !area_chip_select_n_o[s.area])
        else $error("extension without chip select");
    a_release_quiet: assert property ( // [RULE17]
        !bus_ack_n_o |-> area_chip_select_n_o == 8'hFF && !data_oe_o)
        else $error("bus driven while released");

endmodule

// ==== include/ext_area_pkg.sv ====
package ext_area_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_WIDTH  = 12'h000;
    localparam logic [11:0] OFS_ACCESS = 12'h004;
    localparam logic [11:0] OFS_WAIT_U = 12'h008;
    localparam logic [11:0] OFS_WAIT_L = 12'h00C;
    localparam logic [11:0] OFS_CSEXT  = 12'h010;
    localparam logic [11:0] OFS_CTRL   = 12'h014;
    localparam logic [11:0] OFS_MODE   = 12'h018;
    localparam logic [11:0] OFS_ENDIAN = 12'h01C;
    localparam logic [11:0] OFS_STATUS = 12'h020;

    // reset values
    localparam logic [15:0] WIDTH_RST_16 = 16'hFEFF;
    localparam logic [15:0] WIDTH_RST_8  = 16'hFFFF;
    localparam logic [7:0]  ACCESS_RST   = 8'hFF;
    localparam logic [23:0] WAIT_RST     = 24'hFFFFFF;
    localparam logic [6:0]  CTRL_RST     = 7'h00;

    // field positions
    localparam int WIDTH_HIGH_POS = 8;  // width_high_bit n at 8+n
    localparam int ACCESS_POS     = 8;  // access_state_bit n at 8+n
    localparam int WAIT_BITS      = 3;
    localparam int CTRL_IDLE_POS  = 0;  // four idle enables, bits 3:0
    localparam int CTRL_RD_EARLY  = 4;
    localparam int CTRL_REL_EN    = 5;
    localparam int CTRL_WBUF_EN   = 6;
    localparam int MODE_BCTL_POS  = 0;  // byte-control sram, bits 7:0
    localparam int MODE_MUX_POS   = 8;  // multiplexed i/o, bits 15:8
    localparam int MODE_BURST_POS = 16; // burst enable, bits 17:16
    localparam int MODE_BLEN_POS  = 18; // burst beats, 2 bits per area

    // areas that may use the special interfaces
    localparam logic [7:0] MUX_AREAS   = 8'hF8;
    localparam logic [7:0] BURST_AREAS = 8'h03;

    typedef enum logic [3:0] {
        ST_IDLE, ST_REL, ST_GAP, ST_ADDR, ST_T1, ST_T2,
        ST_WAIT, ST_T3, ST_BURST, ST_EXT
    } bus_state_e;
endpackage

// ==== sim/ext_device_model.sv ====
`timescale 1ns/1ps
// external sram stand-in: answers reads, may stretch any access by wait
module ext_device_model (
    // clock of the controller
    input  wire logic        clk_i,
    // strobes from the controller
    input  wire logic [7:0]  cs_n_i,
    input  wire logic        rd_n_i,
    // clocks of wait stretch per access, 0 answers promptly
    input  wire logic [7:0]  stretch_i,
    // pins back to the controller
    output logic      [15:0] data_o,
    output logic             wait_n_o
);
    localparam logic [15:0] READ_WORD = 16'hA5C3;
    logic [7:0] held;

    initial begin
        data_o = 16'h0000;
        wait_n_o = 1'b1;
        held = 8'h00;
    end

    // toggle while released so a late capture never sees a stale word
    always @(posedge clk_i) begin
        if (!rd_n_i && cs_n_i != 8'hFF) begin
            data_o <= READ_WORD;
        end else begin
            data_o <= ~data_o;
        end
    end

    // hold wait low for the first stretch_i clocks of a select
    always @(posedge clk_i) begin
        if (cs_n_i == 8'hFF) begin
            held <= 8'h00;
            wait_n_o <= 1'b1;
        end else begin
            held <= held + 8'h01;
            wait_n_o <= (held >= stretch_i);
        end
    end
endmodule

// ==== sim/external_bus_area_config_test.sv ====
`timescale 1ns/1ps
module external_bus_area_config_test;
    import ext_area_pkg::*;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [2:0]  req_i = 3'h0;
    logic [8:0]  req_area_i = 9'h000;
    logic [2:0]  req_write_i = 3'h0;
    logic [47:0] req_wdata_i = 48'h1234_5678_9ABC;
    logic [2:0]  ack_o;
    logic [15:0] rdata_o;
    logic        bus_clk_i = 1'b0;
    logic        wait_n_i;
    logic        strap_16bit_i = 1'b1;
    logic [7:0]  cs_n;
    logic        rd_n;
    logic        bus_req_n = 1'b1;
    logic        bus_ack_n;
    logic [15:0] data_i;
    logic [7:0]  stretch = 8'h00;
    logic [31:0] rd;
    logic [15:0] got_rd;
    logic [7:0]  cs_seen;
    logic        err;
    int          edges;
    int          n_mismatch = 0;
    int          num_checks = 0;

    always #12.5 clk_i = ~clk_i;
    // bus clock free running, phase unrelated to clk_i
    initial begin
        #37;
        forever #100 bus_clk_i = ~bus_clk_i;
    end

    ext_area_ctrl ext_area_ctrl_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .req_i(req_i), .req_area_i(req_area_i),
        .req_write_i(req_write_i), .req_wdata_i(req_wdata_i),
        .dma_single_i(1'b0), .ack_o(ack_o), .rdata_o(rdata_o),
        .bus_clk_i(bus_clk_i), .wait_n_i(wait_n_i), .bus_req_n_i(bus_req_n),
        .strap_16bit_i(strap_16bit_i), .area_chip_select_n_o(cs_n),
        .bus_start_n_o(), .rd_n_o(rd_n), .wr_n_o(), .read_write_o(),
        .addr_latch_o(), .upper_byte_n_o(), .lower_byte_n_o(),
        .bus_ack_n_o(bus_ack_n), .data_i(data_i), .data_o(), .data_oe_o()
    );

    ext_device_model ext_device_model_inst (
        .clk_i(clk_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .stretch_i(stretch), .data_o(data_i), .wait_n_o(wait_n_i)
    );

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error land in rd and err
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int i;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (pready_o === 1'b1) break;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (i == 50) begin
            n_mismatch++;
            results();
        end
    endtask

    task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // strap must be steady well before release, so set it with reset
    task automatic do_reset(input logic strap);
        resetn_i <= 1'b0;
        strap_16bit_i <= strap;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
    endtask

    // cpu read; counts bus clock rises while a select is low
    task automatic cpu_read(input logic [2:0] area, input logic wr = 1'b0);
        int i;
        logic prev;
        edges = 0;
        cs_seen = 8'hFF;
        @(posedge clk_i);
        req_i <= 3'b001;
        req_area_i <= {6'h00, area};
        req_write_i <= {2'b00, wr};
        prev = bus_clk_i;
        for (i = 0; i < 400; i++) begin
            @(posedge clk_i);
            if (cs_n != 8'hFF) cs_seen = cs_n;
            if (cs_n != 8'hFF && bus_clk_i && !prev) edges++;
            prev = bus_clk_i;
            if (ack_o[0] === 1'b1) break;
        end
        got_rd = rdata_o;
        req_i <= 3'b000;
        if (i == 400) begin
            n_mismatch++;
            results();
        end
    endtask

    // external master takes the bus once the engine is idle
    task automatic release_bus();
        int i;
        bus_req_n <= 1'b0;
        for (i = 0; i < 400; i++) begin
            @(posedge clk_i);
            if (bus_ack_n === 1'b0) break;
        end
        if (i == 400) begin
            n_mismatch++;
            results();
        end
        chk({24'h0, cs_n}, 32'h0000_00FF);
        repeat (8) @(posedge clk_i);
        chk({31'h0, bus_ack_n}, 32'h0);
        bus_req_n <= 1'b1;
        repeat (40) @(posedge clk_i);
        chk({31'h0, bus_ack_n}, 32'h1);
    endtask

    initial begin
        do_reset(1'b1);
        reg_chk(OFS_WIDTH, 32'h0000_FEFF);
        reg_chk(OFS_ACCESS, 32'h0000_FF00);
        reg_chk(OFS_WAIT_L, 32'h0000_7777);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // low byte writes must not stick; all areas become 2-state
        apb(1'b1, OFS_ACCESS, 32'h0000_00FF);
        reg_chk(OFS_ACCESS, 32'h0000_0000);
        cpu_read(3'd0);
        chk(edges, 2);
        chk({24'h0, cs_seen}, 32'h0000_00FE);
        chk({16'h0, got_rd}, 32'h0000_A5C3);
        // area 5: 3-state, wait field 0, 8-bit
        apb(1'b1, OFS_ACCESS, 32'h0000_2000);
        apb(1'b1, OFS_WAIT_U, 32'h0000_7707);
        cpu_read(3'd5);
        chk(edges, 3);
        chk({24'h0, cs_seen}, 32'h0000_00DF);
        chk({16'h0, got_rd}, 32'h0000_00C3);
        apb(1'b1, OFS_WAIT_U, 32'h0000_7737);
        reg_chk(OFS_WAIT_U, 32'h0000_7737);
        cpu_read(3'd5);
        chk(edges, 6);
        // the device holds wait low well past T2
        apb(1'b1, OFS_WAIT_U, 32'h0000_7707);
        stretch <= 8'd40;
        cpu_read(3'd5);
        stretch <= 8'd0;
        chk({31'h0, edges > 3}, 32'h1);
        // area 5 to 16-bit; byte control stays off, so no 8-bit clash
        apb(1'b1, OFS_WIDTH, 32'h0000_DEFF);
        reg_chk(OFS_WIDTH, 32'h0000_DEFF);
        apb(1'b1, OFS_CSEXT, 32'h0000_0020);
        cpu_read(3'd5);
        chk({16'h0, got_rd}, 32'h0000_A5C3);
        // the select of area 5 stays low past the ack
        chk({24'h0, cs_n}, 32'h0000_00DF);
        apb(1'b1, OFS_CSEXT, 32'h0000_0000);
        // buffered write acks at once; release waits for the write
        apb(1'b1, OFS_CTRL, 32'h0000_0060);
        cpu_read(3'd5, 1'b1);
        chk(edges, 0);
        release_bus();
        // 8-bit boot: area 0 narrow, 3-state with seven waits
        do_reset(1'b0);
        reg_chk(OFS_WIDTH, 32'h0000_FFFF);
        cpu_read(3'd0);
        chk(edges, 10);
        chk({16'h0, got_rd}, 32'h0000_00C3);
        results();
    end
endmodule
